// ==== rtl/coc_pkg.sv ====
// package for the comparator output conditioner: register map, fields, reset values
// assumes a plain register port with 8-bit data and read data one cycle after the strobe
package coc_pkg;
   localparam int unsigned ADDR_W = 3;
   localparam int unsigned DATA_W = 8;
   localparam logic [ADDR_W-1:0] OFS_CTRL = 3'h0;
   localparam logic [ADDR_W-1:0] OFS_FILT = 3'h1;
   localparam logic [ADDR_W-1:0] OFS_PERIOD = 3'h2;
   localparam logic [ADDR_W-1:0] OFS_DAC = 3'h3;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 3'h4;
   localparam logic [ADDR_W-1:0] OFS_MUX = 3'h5;
   // control register fields
   localparam int unsigned CTRL_EN = 0;
   localparam int unsigned CTRL_INV = 1;
   localparam int unsigned CTRL_OUTSEL = 2;
   localparam int unsigned CTRL_PIN_EN = 3;
   localparam int unsigned CTRL_WIN_ZERO = 4;
   localparam int unsigned CTRL_MODE_LO = 5;
   localparam int unsigned CTRL_MODE_HI = 6;
   // filter register: [2:0] internal count, [6:4] external count
   localparam int unsigned FILT_ICNT_LO = 0;
   localparam int unsigned FILT_ECNT_LO = 4;
   // dac register is the code; mux register [2:0] plus, [5:3] minus, [6] ref b
   localparam int unsigned MUX_PLUS_LO = 0;
   localparam int unsigned MUX_MINUS_LO = 3;
   localparam int unsigned MUX_REF_B = 6;
   // status register fields
   localparam int unsigned ST_RISE = 0;
   localparam int unsigned ST_FALL = 1;
   localparam int unsigned ST_RISE_IE = 2;
   localparam int unsigned ST_FALL_IE = 3;
   localparam int unsigned ST_DMA_EN = 4;
   localparam int unsigned ST_OUT = 5;
   localparam int unsigned ST_ACTIVE = 6;
   localparam logic [DATA_W-1:0] RST_CTRL = 8'h00;
   localparam logic [DATA_W-1:0] RST_FILT = 8'h10;
   localparam logic [DATA_W-1:0] RST_ZERO = 8'h00;
   localparam logic [2:0] CNT_ONE = 3'h1;
   localparam logic [2:0] CNT_OFF = 3'h0;
   localparam logic [7:0] PERIOD_OFF = 8'h00;
   localparam logic [7:0] DIV_START = 8'h01;

   typedef enum logic [1:0] {
      COC_MODE_BYPASS = 2'h0,
      COC_MODE_EXT = 2'h1,
      COC_MODE_WINDOW = 2'h2
   } coc_mode_t;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic wr;
      logic rd;
   } coc_bus_req_t;

   typedef struct packed {
      logic [7:0] code;
      logic ref_b;
      logic enable;
   } coc_dac_t;
endpackage

// ==== rtl/coc_sync2.sv ====
// two-flop synchroniser for levels coming from outside the clock domain
// assumes the input is a level held longer than two clock periods
`timescale 1ns/1ps
module coc_sync2 (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic ce_in,
   input wire logic d_in,
   output logic q_out
);
   logic meta_q;
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         meta_q <= 1'b0;
         q_out <= 1'b0;
      end else if (ce_in) begin
         meta_q <= d_in;
         q_out <= meta_q;
      end
   end
endmodule // coc_sync2

// ==== rtl/coc_filter.sv ====
// consecutive-sample glitch filter: accepts a new state after cnt agreeing samples
// assumes sample_in is a one-cycle pulse on the same clock
`timescale 1ns/1ps
module coc_filter (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic ce_in,
   input wire logic sample_in,
   input wire logic [2:0] cnt_in,
   input wire logic d_in,
   output logic q_out
);
   import coc_pkg::*;
   logic [2:0] agree_q;
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         agree_q <= CNT_OFF;
         q_out <= 1'b0;
      end else if (ce_in && sample_in) begin
         if (d_in == q_out) begin
            agree_q <= CNT_OFF;
         end else if (agree_q + CNT_ONE >= cnt_in) begin
            q_out <= d_in;
            agree_q <= CNT_OFF;
         end else begin
            agree_q <= agree_q + CNT_ONE;
         end
      end
   end
endmodule // coc_filter

// ==== rtl/coc_top.sv ====
// comparator output conditioner: polarity, window, filter, edge flags, irq/dma, dac code
// assumes an analog comparator result and window/sample strobes from outside the clock domain
//
// Implementation choices: the register addresses and the strobed register port.
`timescale 1ns/1ps
module coc_top (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic ce_in,
   input wire logic cmp_raw_in,
   input wire logic window_in,
   input wire logic ext_sample_in,
   input wire coc_pkg::coc_bus_req_t bus_in,
   output logic [coc_pkg::DATA_W-1:0] rdata_out,
   output logic irq_out,
   output logic dma_req_out,
   output logic compare_out_pin_out,
   output logic compare_out_pin_oe_n_out,
   output coc_pkg::coc_dac_t dac_out,
   output logic analog_en_out,
   output logic [2:0] plus_sel_out,
   output logic [2:0] minus_sel_out
);
   import coc_pkg::*;

   logic [DATA_W-1:0] ctrl_q, filt_q, period_q, dac_code_q, mux_q;
   logic rise_flag_q, fall_flag_q;
   logic rise_ie_q, fall_ie_q, dma_request_enable_q;
   logic raw_s, win_s, samp_s, samp_s_q;
   logic inv_d, win_q, unfilt_q, filt_out, filtered_compare_out, unfiltered_compare_out;
   logic cond_d, cond_q;
   logic [7:0] div_q;
   logic div_tick, samp_pulse, filt_bypass;
   coc_mode_t mode;
   logic [2:0] icnt, ecnt, eff_cnt;
   logic same_src, active;

   assign mode = coc_mode_t'(ctrl_q[CTRL_MODE_HI:CTRL_MODE_LO]);
   assign icnt = filt_q[FILT_ICNT_LO +: 3];
   assign ecnt = filt_q[FILT_ECNT_LO +: 3];
   assign same_src = (mux_q[MUX_PLUS_LO +: 3] == mux_q[MUX_MINUS_LO +: 3]);
   assign active = ctrl_q[CTRL_EN] && !same_src;

   wire wr_hit = bus_in.wr;
   wire rd_hit = bus_in.rd;

   // register writes
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ctrl_q <= RST_CTRL;
         filt_q <= RST_FILT;
         period_q <= RST_ZERO;
         dac_code_q <= RST_ZERO;
         mux_q <= RST_ZERO;
         rise_ie_q <= 1'b0;
         fall_ie_q <= 1'b0;
         dma_request_enable_q <= 1'b0;
      end else if (ce_in && wr_hit) begin
         case (bus_in.addr)
            OFS_CTRL: ctrl_q <= bus_in.wdata;
            OFS_FILT: filt_q <= bus_in.wdata;
            OFS_PERIOD: period_q <= bus_in.wdata;
            OFS_DAC: dac_code_q <= bus_in.wdata;
            OFS_MUX: mux_q <= bus_in.wdata;
            OFS_STATUS: begin
               rise_ie_q <= bus_in.wdata[ST_RISE_IE];
               fall_ie_q <= bus_in.wdata[ST_FALL_IE];
               dma_request_enable_q <= bus_in.wdata[ST_DMA_EN];
            end
            default: ;
         endcase
      end
   end

   // external inputs cross into the clock domain
   coc_sync2 u_sync_raw (.clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(ce_in),
      .d_in(cmp_raw_in), .q_out(raw_s));
   coc_sync2 u_sync_win (.clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(ce_in),
      .d_in(window_in), .q_out(win_s));
   coc_sync2 u_sync_samp (.clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(ce_in),
      .d_in(ext_sample_in), .q_out(samp_s));

   assign inv_d = (raw_s ^ ctrl_q[CTRL_INV]) & active;

   // unfiltered path with window gate
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         unfilt_q <= 1'b0;
         win_q <= 1'b0;
      end else if (ce_in) begin
         win_q <= win_s;
         if (mode != COC_MODE_WINDOW || win_s) begin
            unfilt_q <= inv_d;
         end else if (ctrl_q[CTRL_WIN_ZERO]) begin
            unfilt_q <= 1'b0;
         end else begin
            unfilt_q <= unfilt_q;
         end
      end
   end
   assign unfiltered_compare_out = unfilt_q;

   // sample clock divider; period zero stops the internally clocked filter
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         div_q <= DIV_START;
         samp_s_q <= 1'b0;
      end else if (ce_in) begin
         samp_s_q <= samp_s;
         if (div_tick || period_q == PERIOD_OFF) begin
            div_q <= DIV_START;
         end else begin
            div_q <= div_q + DIV_START;
         end
      end
   end
   assign div_tick = (period_q != PERIOD_OFF) && (div_q >= period_q);
   assign filt_bypass = (mode != COC_MODE_EXT) &&
      (icnt == CNT_OFF || period_q == PERIOD_OFF);
   assign samp_pulse = (mode == COC_MODE_EXT) ? (samp_s && !samp_s_q) : div_tick;
   assign eff_cnt = (mode == COC_MODE_EXT) ? ((ecnt == CNT_OFF) ? CNT_ONE : ecnt) : icnt;

   coc_filter u_filter (.clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(ce_in),
      .sample_in(samp_pulse), .cnt_in(eff_cnt), .d_in(unfilt_q), .q_out(filt_out));
   assign filtered_compare_out = filt_bypass ? unfilt_q : filt_out;

   assign cond_d = ctrl_q[CTRL_OUTSEL] ? unfiltered_compare_out : filtered_compare_out;

   wire rise_ev = cond_d && !cond_q;
   wire fall_ev = !cond_d && cond_q;
   wire clr_wr = wr_hit && bus_in.addr == OFS_STATUS;

   // edge flags: an edge in the clear cycle wins
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cond_q <= 1'b0;
         rise_flag_q <= 1'b0;
         fall_flag_q <= 1'b0;
      end else if (ce_in) begin
         cond_q <= cond_d;
         rise_flag_q <= rise_ev || (rise_flag_q && !(clr_wr && bus_in.wdata[ST_RISE]));
         fall_flag_q <= fall_ev || (fall_flag_q && !(clr_wr && bus_in.wdata[ST_FALL]));
      end
   end

   // irq and dma requests
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         irq_out <= 1'b0;
         dma_req_out <= 1'b0;
      end else if (ce_in) begin
         // dma takes the enabled edges, so the irq stays quiet while it is on
         irq_out <= !dma_request_enable_q &&
            ((rise_ie_q && rise_flag_q) || (fall_ie_q && fall_flag_q));
         dma_req_out <= dma_request_enable_q &&
            ((rise_ie_q && rise_ev) || (fall_ie_q && fall_ev));
      end
   end

   // pins, dac and read data
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         compare_out_pin_out <= 1'b0;
         compare_out_pin_oe_n_out <= 1'b1;
         dac_out <= '0;
         analog_en_out <= 1'b0;
         plus_sel_out <= CNT_OFF;
         minus_sel_out <= CNT_OFF;
         rdata_out <= RST_ZERO;
      end else if (ce_in) begin
         compare_out_pin_out <= cond_d & ctrl_q[CTRL_PIN_EN];
         compare_out_pin_oe_n_out <= !ctrl_q[CTRL_PIN_EN];
         dac_out.code <= dac_code_q;
         dac_out.ref_b <= mux_q[MUX_REF_B];
         dac_out.enable <= active;
         analog_en_out <= active;
         plus_sel_out <= mux_q[MUX_PLUS_LO +: 3];
         minus_sel_out <= mux_q[MUX_MINUS_LO +: 3];
         rdata_out <= RST_ZERO;
         if (rd_hit) begin
            case (bus_in.addr)
               OFS_CTRL: rdata_out <= ctrl_q;
               OFS_FILT: rdata_out <= filt_q;
               OFS_PERIOD: rdata_out <= period_q;
               OFS_DAC: rdata_out <= dac_code_q;
               OFS_MUX: rdata_out <= mux_q;
               OFS_STATUS: rdata_out <= {1'b0, active, cond_q, dma_request_enable_q,
                  fall_ie_q, rise_ie_q, fall_flag_q, rise_flag_q};
               default: rdata_out <= RST_ZERO;
            endcase
         end
      end
   end

   // checks
   property p_zero_win;
      @(posedge clk_in) disable iff (!rst_n_in)
      (ce_in && mode == COC_MODE_WINDOW && !win_s && ctrl_q[CTRL_WIN_ZERO]) |=> !unfilt_q;
   endproperty
   a_zero_win: assert property (p_zero_win) else $error("zero window not forced");
   property p_hold_win;
      @(posedge clk_in) disable iff (!rst_n_in)
      (ce_in && mode == COC_MODE_WINDOW && !win_s && !ctrl_q[CTRL_WIN_ZERO])
         |=> $stable(unfilt_q);
   endproperty
   a_hold_win: assert property (p_hold_win) else $error("hold window changed");
   property p_rise_flag;
      @(posedge clk_in) disable iff (!rst_n_in) (ce_in && rise_ev) |=> rise_flag_q;
   endproperty
   a_rise_flag: assert property (p_rise_flag) else $error("rise flag missing");
   property p_fall_flag;
      @(posedge clk_in) disable iff (!rst_n_in) (ce_in && fall_ev) |=> fall_flag_q;
   endproperty
   a_fall_flag: assert property (p_fall_flag) else $error("fall flag missing");
   property p_dma_no_irq;
      @(posedge clk_in) disable iff (!rst_n_in) (ce_in && dma_request_enable_q) |=> !irq_out;
   endproperty
   a_dma_no_irq: assert property (p_dma_no_irq) else $error("irq with dma on");
   property p_irq_level;
      @(posedge clk_in) disable iff (!rst_n_in)
      (ce_in && !dma_request_enable_q && rise_ie_q && rise_flag_q) |=> irq_out;
   endproperty
   a_irq_level: assert property (p_irq_level) else $error("irq not raised");
   property p_dma_req;
      @(posedge clk_in) disable iff (!rst_n_in)
      (ce_in && dma_request_enable_q && fall_ie_q && fall_ev) |=> dma_req_out;
   endproperty
   a_dma_req: assert property (p_dma_req) else $error("dma request missing");
   property p_same_src;
      @(posedge clk_in) disable iff (!rst_n_in) (ce_in && same_src) |=> !analog_en_out;
   endproperty
   a_same_src: assert property (p_same_src) else $error("same source left enabled");
   property p_pin_off;
      @(posedge clk_in) disable iff (!rst_n_in)
      (ce_in && !ctrl_q[CTRL_PIN_EN]) |=> compare_out_pin_oe_n_out && !compare_out_pin_out;
   endproperty
   a_pin_off: assert property (p_pin_off) else $error("pin driven while off");
   property p_irq_off;
      @(posedge clk_in) disable iff (!rst_n_in)
      (ce_in && !rise_ie_q && !fall_ie_q) |=> !irq_out;
   endproperty
   a_irq_off: assert property (p_irq_off) else $error("irq without enable");
   property p_fall_irq;
      @(posedge clk_in) disable iff (!rst_n_in)
      (ce_in && !dma_request_enable_q && fall_ie_q && fall_flag_q) |=> irq_out;
   endproperty
   a_fall_irq: assert property (p_fall_irq) else $error("fall irq missing");
   property p_dma_off;
      @(posedge clk_in) disable iff (!rst_n_in)
      (ce_in && !dma_request_enable_q) |=> !dma_req_out;
   endproperty
   a_dma_off: assert property (p_dma_off) else $error("dma request while off");
   property p_dma_rise;
      @(posedge clk_in) disable iff (!rst_n_in)
      (ce_in && dma_request_enable_q && rise_ie_q && rise_ev) |=> dma_req_out;
   endproperty
   a_dma_rise: assert property (p_dma_rise) else $error("rise dma missing");
   property p_both_flags;
      @(posedge clk_in) disable iff (!rst_n_in)
      (ce_in && rise_flag_q && fall_ev && !clr_wr) |=> rise_flag_q && fall_flag_q;
   endproperty
   a_both_flags: assert property (p_both_flags) else $error("flags not both set");
   property p_rise_hold;
      @(posedge clk_in) disable iff (!rst_n_in)
      (ce_in && rise_flag_q && !(clr_wr && bus_in.wdata[ST_RISE])) |=> rise_flag_q;
   endproperty
   a_rise_hold: assert property (p_rise_hold) else $error("rise flag lost");
   property p_rise_clear;
      @(posedge clk_in) disable iff (!rst_n_in)
      (ce_in && clr_wr && bus_in.wdata[ST_RISE] && !rise_ev) |=> !rise_flag_q;
   endproperty
   a_rise_clear: assert property (p_rise_clear) else $error("rise flag not cleared");
   property p_fall_clear;
      @(posedge clk_in) disable iff (!rst_n_in)
      (ce_in && clr_wr && bus_in.wdata[ST_FALL] && !fall_ev) |=> !fall_flag_q;
   endproperty
   a_fall_clear: assert property (p_fall_clear) else $error("fall flag not cleared");
   property p_win_bypass;
      @(posedge clk_in) disable iff (!rst_n_in)
      (ce_in && mode != COC_MODE_WINDOW) |=> unfilt_q == $past(inv_d);
   endproperty
   a_win_bypass: assert property (p_win_bypass) else $error("gate acts outside window");
   property p_win_open;
      @(posedge clk_in) disable iff (!rst_n_in)
      (ce_in && mode == COC_MODE_WINDOW && win_s) |=> unfilt_q == $past(inv_d);
   endproperty
   a_win_open: assert property (p_win_open) else $error("open gate blocks result");
   property p_invert;
      @(posedge clk_in) disable iff (!rst_n_in)
      (ce_in && active && mode != COC_MODE_WINDOW && ctrl_q[CTRL_INV]) |=> unfilt_q != $past(raw_s);
   endproperty
   a_invert: assert property (p_invert) else $error("result not inverted");
   property p_outsel;
      @(posedge clk_in) disable iff (!rst_n_in)
      (ce_in && ctrl_q[CTRL_OUTSEL]) |=> cond_q == $past(unfilt_q);
   endproperty
   a_outsel: assert property (p_outsel) else $error("unfiltered route wrong");
   property p_period_off;
      @(posedge clk_in) disable iff (!rst_n_in)
      (ce_in && !ctrl_q[CTRL_OUTSEL] && mode != COC_MODE_EXT && period_q == PERIOD_OFF)
         |=> cond_q == $past(unfilt_q);
   endproperty
   a_period_off: assert property (p_period_off) else $error("period zero filters");
   property p_count_off;
      @(posedge clk_in) disable iff (!rst_n_in)
      (ce_in && !ctrl_q[CTRL_OUTSEL] && mode != COC_MODE_EXT && icnt == CNT_OFF)
         |=> cond_q == $past(unfilt_q);
   endproperty
   a_count_off: assert property (p_count_off) else $error("count zero filters");
   property p_filt_tick;
      @(posedge clk_in) disable iff (!rst_n_in)
      !(ce_in && samp_pulse) |=> $stable(filt_out);
   endproperty
   a_filt_tick: assert property (p_filt_tick) else $error("filter moved off tick");
   property p_div_gap;
      @(posedge clk_in) disable iff (!rst_n_in)
      (ce_in && !wr_hit && div_tick && period_q > DIV_START) |=> !div_tick;
   endproperty
   a_div_gap: assert property (p_div_gap) else $error("sample ticks too close");
   property p_ext_strobe;
      @(posedge clk_in) disable iff (!rst_n_in)
      (ce_in && mode == COC_MODE_EXT && !samp_s) |=> $stable(filt_out);
   endproperty
   a_ext_strobe: assert property (p_ext_strobe) else $error("sample without strobe");
   property p_dac_code;
      @(posedge clk_in) disable iff (!rst_n_in)
      ce_in |=> dac_out.code == $past(dac_code_q) && dac_out.ref_b == $past(mux_q[MUX_REF_B]);
   endproperty
   a_dac_code: assert property (p_dac_code) else $error("dac code or ref wrong");
   property p_pin_on;
      @(posedge clk_in) disable iff (!rst_n_in)
      (ce_in && ctrl_q[CTRL_PIN_EN]) |=> !compare_out_pin_oe_n_out && compare_out_pin_out == $past(cond_d);
   endproperty
   a_pin_on: assert property (p_pin_on) else $error("pin not driven");
   property p_active;
      @(posedge clk_in) disable iff (!rst_n_in)
      (ce_in && ctrl_q[CTRL_EN] && !same_src) |=> analog_en_out && dac_out.enable;
   endproperty
   a_active: assert property (p_active) else $error("comparator not enabled");
   c_rise: cover property (@(posedge clk_in) disable iff (!rst_n_in) rise_ev ##[1:20] fall_ev);
   c_dma: cover property (@(posedge clk_in) disable iff (!rst_n_in) dma_req_out);
   c_irq: cover property (@(posedge clk_in) disable iff (!rst_n_in) irq_out);
   c_win: cover property (@(posedge clk_in) disable iff (!rst_n_in)
      mode == COC_MODE_WINDOW && win_q && !win_s);
endmodule // coc_top

// ==== test/coc_testbench.sv ====
// self-checking bench for the comparator output conditioner
// assumes coc_pkg and coc_top are compiled first; the bench drives every port itself
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_fail++; $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module testbench;
   import coc_pkg::*;
   logic clk_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic ce_in = 1'b1;
   logic cmp_raw_in = 1'b0;
   logic window_in = 1'b0;
   logic ext_sample_in = 1'b0;
   coc_bus_req_t bus_in = '0;
   logic [DATA_W-1:0] rdata_out;
   logic irq_out;
   logic dma_req_out;
   logic pin_out;
   logic pin_oe_n;
   coc_dac_t dac_out;
   logic analog_en_out;
   logic [2:0] plus_sel_out;
   logic [2:0] minus_sel_out;
   int n_fail = 0;
   int checked = 0;
   int cycles = 0;
   int n_dma = 0;
   int n_irq = 0;
   logic [7:0] rv;

   coc_top i_dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(ce_in), .cmp_raw_in(cmp_raw_in),
      .window_in(window_in), .ext_sample_in(ext_sample_in), .bus_in(bus_in),
      .rdata_out(rdata_out), .irq_out(irq_out), .dma_req_out(dma_req_out),
      .compare_out_pin_out(pin_out), .compare_out_pin_oe_n_out(pin_oe_n), .dac_out(dac_out),
      .analog_en_out(analog_en_out), .plus_sel_out(plus_sel_out), .minus_sel_out(minus_sel_out));

   initial begin
      forever #10 clk_in = ~clk_in;
   end

   // the whole run needs a few hundred cycles; anything far beyond is a hang
   always @(posedge clk_in) begin
      cycles++;
      if (dma_req_out === 1'b1) n_dma++;
      if (irq_out === 1'b1) n_irq++;
      if (cycles == 20000) begin
         n_fail++;
         wrap_up();
      end
   end

   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk_in);
   endtask

   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk_in);
      bus_in <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk_in);
      bus_in.wr <= 1'b0;
   endtask

   // read data stands only in the cycle after the strobe, so sample just past that edge
   task automatic rd(input logic [2:0] a, output logic [7:0] d);
      @(posedge clk_in);
      bus_in <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk_in);
      bus_in.rd <= 1'b0;
      #1;
      d = rdata_out;
      // back on the edge so the caller's next stimulus is edge aligned
      @(posedge clk_in);
   endtask

   task automatic out_chk(input logic e);
      rd(OFS_STATUS, rv);
      `CHK(rv[ST_OUT], e)
   endtask

   task automatic restart(input logic [7:0] ctrl);
      @(posedge clk_in);
      rst_n_in <= 1'b0;
      cmp_raw_in <= 1'b0;
      window_in <= 1'b0;
      ext_sample_in <= 1'b0;
      cyc(2);
      rst_n_in <= 1'b1;
      wr(OFS_MUX, 8'h0a);
      wr(OFS_CTRL, ctrl);
   endtask

   task automatic s_reset_regs();
      rd(OFS_CTRL, rv);
      `CHK(rv, RST_CTRL)
      rd(OFS_FILT, rv);
      `CHK(rv, RST_FILT)
      rd(3'h6, rv);
      `CHK(rv, RST_ZERO)
      `CHK(pin_oe_n, 1'b1)
      wr(OFS_CTRL, 8'h01);
      cyc(2);
      `CHK(analog_en_out, 1'b0)
      wr(OFS_MUX, 8'h4a);
      wr(OFS_DAC, 8'ha5);
      cyc(2);
      `CHK(analog_en_out, 1'b1)
      `CHK(dac_out.ref_b, 1'b1)
      `CHK(dac_out.code, 8'ha5)
      `CHK(dac_out.enable, 1'b1)
      `CHK({plus_sel_out, minus_sel_out}, 6'h11)
   endtask

   task automatic s_edges();
      restart(8'h0d);
      wr(OFS_STATUS, 8'h04);
      cmp_raw_in <= 1'b1;
      cyc(2);
      `CHK(irq_out, 1'b0)
      cyc(6);
      `CHK(irq_out, 1'b1)
      `CHK({pin_out, pin_oe_n}, 2'b10)
      cmp_raw_in <= 1'b0;
      cyc(8);
      rd(OFS_STATUS, rv);
      `CHK(rv[1:0], 2'b11)
      wr(OFS_STATUS, 8'h05);
      cyc(3);
      `CHK(irq_out, 1'b0)
      wr(OFS_STATUS, 8'h08);
      cyc(3);
      `CHK(irq_out, 1'b1)
      wr(OFS_STATUS, 8'h0a);
      cyc(3);
      `CHK(irq_out, 1'b0)
      wr(OFS_CTRL, 8'h05);
      cyc(3);
      `CHK({pin_out, pin_oe_n}, 2'b01)
   endtask

   task automatic s_dma();
      int d0;
      int i0;
      restart(8'h05);
      wr(OFS_STATUS, 8'h14);
      d0 = n_dma;
      i0 = n_irq;
      cmp_raw_in <= 1'b1;
      cyc(10);
      cmp_raw_in <= 1'b0;
      cyc(10);
      `CHK(n_dma - d0, 1)
      wr(OFS_STATUS, 8'h1c);
      cmp_raw_in <= 1'b1;
      cyc(10);
      cmp_raw_in <= 1'b0;
      cyc(10);
      `CHK(n_dma - d0, 3)
      `CHK(n_irq - i0, 0)
      wr(OFS_STATUS, 8'h13);
      cmp_raw_in <= 1'b1;
      cyc(10);
      `CHK(n_dma - d0, 3)
   endtask

   task automatic s_invert();
      restart(8'h07);
      cyc(6);
      out_chk(1'b1);
      cmp_raw_in <= 1'b1;
      cyc(6);
      out_chk(1'b0);
   endtask

   task automatic s_window();
      restart(8'h55);
      window_in <= 1'b1;
      cmp_raw_in <= 1'b1;
      cyc(8);
      out_chk(1'b1);
      window_in <= 1'b0;
      cyc(8);
      out_chk(1'b0);
      wr(OFS_CTRL, 8'h45);
      window_in <= 1'b1;
      cyc(8);
      window_in <= 1'b0;
      cyc(6);
      cmp_raw_in <= 1'b0;
      cyc(8);
      out_chk(1'b1);
      wr(OFS_CTRL, 8'h15);
      cmp_raw_in <= 1'b1;
      cyc(8);
      out_chk(1'b1);
   endtask

   task automatic s_filter();
      restart(8'h01);
      wr(OFS_FILT, 8'h13);
      wr(OFS_PERIOD, 8'h04);
      cmp_raw_in <= 1'b1;
      cyc(3);
      cmp_raw_in <= 1'b0;
      cyc(30);
      out_chk(1'b0);
      // eight cycles hold at most two agreeing samples, one short of the count
      cmp_raw_in <= 1'b1;
      cyc(8);
      out_chk(1'b0);
      cyc(24);
      out_chk(1'b1);
      wr(OFS_FILT, 8'h17);
      wr(OFS_PERIOD, PERIOD_OFF);
      cmp_raw_in <= 1'b0;
      cyc(6);
      out_chk(1'b0);
   endtask

   // the strobe is held several cycles so each rise survives the synchroniser
   task automatic strobe();
      ext_sample_in <= 1'b1;
      cyc(4);
      ext_sample_in <= 1'b0;
      cyc(4);
   endtask

   task automatic s_ext();
      restart(8'h21);
      wr(OFS_FILT, 8'h20);
      cmp_raw_in <= 1'b1;
      cyc(20);
      out_chk(1'b0);
      strobe();
      cyc(4);
      out_chk(1'b0);
      strobe();
      cyc(6);
      out_chk(1'b1);
   endtask

   // a low enable must freeze every register, bus writes included
   task automatic s_freeze();
      restart(8'h05);
      cyc(2);
      ce_in <= 1'b0;
      cmp_raw_in <= 1'b1;
      wr(OFS_DAC, 8'h3c);
      cyc(10);
      `CHK({dac_out.code, analog_en_out}, 9'h001)
      ce_in <= 1'b1;
      rd(OFS_DAC, rv);
      `CHK(rv, RST_ZERO)
   endtask

   initial begin
      repeat (20) @(posedge clk_in);
      rst_n_in <= 1'b1;
      s_reset_regs();
      s_edges();
      s_dma();
      s_invert();
      s_window();
      s_filter();
      s_ext();
      s_freeze();
      wrap_up();
   end
endmodule // testbench
